// ---- rtl/scm_socket_engine.sv ----
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module scm_socket_engine #(
  parameter int N_SOCK = scm_pkg::NUM_SOCK
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      RESET_N,
  input  wire logic [15:0]               S_AXI_AWADDR,
  input  wire logic                      S_AXI_AWVALID,
  output logic                           S_AXI_AWREADY,
  input  wire logic [31:0]               S_AXI_WDATA,
  input  wire logic [3:0]                S_AXI_WSTRB,
  input  wire logic                      S_AXI_WVALID,
  output logic                           S_AXI_WREADY,
  output logic [1:0]                     S_AXI_BRESP,
  output logic                           S_AXI_BVALID,
  input  wire logic                      S_AXI_BREADY,
  input  wire logic [15:0]               S_AXI_ARADDR,
  input  wire logic                      S_AXI_ARVALID,
  output logic                           S_AXI_ARREADY,
  output logic [31:0]                    S_AXI_RDATA,
  output logic [1:0]                     S_AXI_RRESP,
  output logic                           S_AXI_RVALID,
  input  wire logic                      S_AXI_RREADY,
  output scm_pkg::scm_cmd_t [N_SOCK-1:0] ENG_CMD,
  input  wire logic [N_SOCK-1:0]         ENG_DONE,
  input  scm_pkg::scm_evt_t [N_SOCK-1:0] ENG_EVENT,
  output logic [N_SOCK-1:0][7:0]         SOCK_MODE,
  output logic [N_SOCK-1:0][7:0]         SOCK_STATE
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // map a byte address to socket and register
  function automatic scm_pkg::scm_dec_t addr_decode(input logic [15:0] a);
    logic [11:0]       idx;
    scm_pkg::scm_dec_t d;
    idx    = a[13:2];
    d.sock = idx[9:8];
    d.sel  = idx[1:0];
    d.hit  = (a[15:14] == 2'b00) && (idx[11:10] == scm_pkg::IDX_MODE[11:10])
             && (idx[7:2] == 6'h00) && (32'(idx[9:8]) < N_SOCK);
    return d;
  endfunction

  // state reached by open for the selected protocol
  function automatic logic [7:0] open_state(input logic [3:0] p, input logic s0);
    case (p)
      scm_pkg::PROTO_TCP:    open_state = scm_pkg::ST_INIT;
      scm_pkg::PROTO_UDP:    open_state = scm_pkg::ST_DGRAM;
      scm_pkg::PROTO_IP_RAW_MODE:  open_state = scm_pkg::ST_IP_RAW_MODE;
      scm_pkg::PROTO_MAC_RAW_MODE: open_state = s0 ? scm_pkg::ST_MAC_RAW_MODE : scm_pkg::ST_CLOSED;
      scm_pkg::PROTO_PPPOE:  open_state = s0 ? scm_pkg::ST_PPPOE : scm_pkg::ST_CLOSED;
      default:               open_state = scm_pkg::ST_CLOSED;
    endcase
  endfunction

  // whether a command may run in the present mode and state
  function automatic logic cmd_ok(input logic [7:0] c, input logic [3:0] p,
                                  input logic [7:0] st, input logic s0);
    logic tcp;
    tcp = (p == scm_pkg::PROTO_TCP);
    case (c)
      scm_pkg::CMD_OPEN:    cmd_ok = (st == scm_pkg::ST_CLOSED) && (open_state(p, s0) != scm_pkg::ST_CLOSED);
      scm_pkg::CMD_LISTEN:  cmd_ok = tcp && (st == scm_pkg::ST_INIT);
      scm_pkg::CMD_CONNECT: cmd_ok = tcp && (st == scm_pkg::ST_INIT);
      scm_pkg::CMD_DISCONNECT:  cmd_ok = tcp && (st == scm_pkg::ST_ESTAB || st == scm_pkg::ST_CLOSE_WT);
      scm_pkg::CMD_CLOSE:   cmd_ok = 1'b1;
      scm_pkg::CMD_SEND:    cmd_ok = (st == scm_pkg::ST_ESTAB) || (st == scm_pkg::ST_CLOSE_WT)
                                     || (st == scm_pkg::ST_DGRAM) || (st == scm_pkg::ST_IP_RAW_MODE)
                                     || (st == scm_pkg::ST_MAC_RAW_MODE) || (st == scm_pkg::ST_PPPOE);
      scm_pkg::CMD_SEND_HW: cmd_ok = (p == scm_pkg::PROTO_UDP) && (st == scm_pkg::ST_DGRAM);
      scm_pkg::CMD_KEEP:    cmd_ok = tcp && (st == scm_pkg::ST_ESTAB);
      scm_pkg::RECEIVE_COMMAND:    cmd_ok = (st != scm_pkg::ST_CLOSED);
      default:              cmd_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------

  logic rst_meta;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  logic [15:0]       aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              aw_full;
  logic              w_full;
  scm_pkg::scm_dec_t wr_dec;
  scm_pkg::scm_dec_t rd_dec;
  logic              wr_go;
  logic              rd_go;
  logic [7:0]        rd_val;

  // per-socket command and event registers, read back over the bus
  logic [N_SOCK-1:0][7:0] sock_cmd;
  logic [N_SOCK-1:0][7:0] sock_evt;

  // write fires once address and data are both held
  assign wr_dec = addr_decode(aw_addr);
  assign wr_go  = aw_full && w_full && !S_AXI_BVALID;
  assign rd_dec = addr_decode(S_AXI_ARADDR);
  assign rd_go  = S_AXI_ARVALID && S_AXI_ARREADY;

  // write address and data channels, taken in either order
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 16'h0000;
      w_data        <= 32'h0000_0000;
      w_lane0       <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_full && !(S_AXI_AWVALID && S_AXI_AWREADY);
      S_AXI_WREADY  <= !w_full && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        aw_full <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full  <= 1'b1;
        w_data  <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= scm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_dec.hit ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // read data selection
  always_comb begin
    case (rd_dec.sel)
      scm_pkg::IDX_MODE[1:0]: rd_val = SOCK_MODE[rd_dec.sock];
      scm_pkg::IDX_CMD[1:0]:  rd_val = sock_cmd[rd_dec.sock];
      scm_pkg::IDX_EVT[1:0]:  rd_val = sock_evt[rd_dec.sock];
      default:                rd_val = SOCK_STATE[rd_dec.sock];
    endcase
  end

  // read channel, one read in flight
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= scm_pkg::RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_dec.hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      S_AXI_RRESP   <= rd_dec.hit ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID;
    end
  end

  // ----------------------------------------------------------------
  // per-socket command, state and event logic
  // ----------------------------------------------------------------

  scm_pkg::scm_seq_t      seq [N_SOCK];

  for (genvar i = 0; i < N_SOCK; i++) begin : g_sock
    logic       s0;
    logic [3:0] proto;
    logic       wr_hit;
    logic       pend;
    logic       ok;
    logic       accept;
    logic       drop;
    logic       tcp_conn;
    logic [7:0] evt_set;
    logic [7:0] evt_clr;
    logic [7:0] next_evt;
    logic [7:0] next_state;

    assign s0     = (i == 0);
    assign proto  = SOCK_MODE[i][3:0];
    assign wr_hit = wr_go && wr_dec.hit && w_lane0 && (32'(wr_dec.sock) == i);
    assign pend   = (seq[i] == scm_pkg::SQ_IDLE) && (sock_cmd[i] != scm_pkg::CMD_RST);
    assign ok     = cmd_ok(sock_cmd[i], proto, SOCK_STATE[i], s0);
    assign accept = pend && ok;
    // invalid commands and close finish at once
    assign drop   = pend && (!ok || sock_cmd[i] == scm_pkg::CMD_CLOSE);
    assign tcp_conn = (SOCK_STATE[i] == scm_pkg::ST_LISTEN) || (SOCK_STATE[i] == scm_pkg::ST_SYNSENT)
                      || (SOCK_STATE[i] == scm_pkg::ST_ESTAB) || (SOCK_STATE[i] == scm_pkg::ST_FIN_WAIT)
                      || (SOCK_STATE[i] == scm_pkg::ST_CLOSE_WT);

    // event sources, set takes priority over a one-write clear
    always_comb begin
      evt_set = 8'h00;
      evt_set[scm_pkg::EVB_SENDOK]  = ENG_EVENT[i].send_done;
      evt_set[scm_pkg::EVB_TIMEOUT] = ENG_EVENT[i].timeout;
      evt_set[scm_pkg::EVB_RECV]    = ENG_EVENT[i].rx_data
                                      || ((seq[i] == scm_pkg::SQ_BUSY) && ENG_DONE[i]
                                          && sock_cmd[i] == scm_pkg::RECEIVE_COMMAND && ENG_EVENT[i].rx_pending);
      evt_set[scm_pkg::EVB_DISCONNECT]  = ENG_EVENT[i].peer_fin || ENG_EVENT[i].term_done;
      evt_set[scm_pkg::EVB_CON]     = ENG_EVENT[i].connected
                                      && (SOCK_STATE[i] == scm_pkg::ST_LISTEN
                                          || SOCK_STATE[i] == scm_pkg::ST_SYNSENT);
      evt_clr  = (wr_hit && wr_dec.sel == scm_pkg::IDX_EVT[1:0]) ? w_data[7:0] : 8'h00;
      next_evt = ((sock_evt[i] & ~evt_clr) | evt_set) & scm_pkg::EVT_MASK;
    end

    // socket state transitions from commands and engine events
    always_comb begin
      next_state = SOCK_STATE[i];
      if (accept) begin
        case (sock_cmd[i])
          scm_pkg::CMD_OPEN:    next_state = open_state(proto, s0);
          scm_pkg::CMD_LISTEN:  next_state = scm_pkg::ST_LISTEN;
          scm_pkg::CMD_CONNECT: next_state = scm_pkg::ST_SYNSENT;
          scm_pkg::CMD_DISCONNECT:  next_state = scm_pkg::ST_FIN_WAIT;
          scm_pkg::CMD_CLOSE:   next_state = scm_pkg::ST_CLOSED;
          default:              next_state = SOCK_STATE[i];
        endcase
      end
      if (!(accept && sock_cmd[i] == scm_pkg::CMD_CLOSE)) begin
        if (ENG_EVENT[i].timeout && tcp_conn) begin
          next_state = scm_pkg::ST_CLOSED;
        end else if (ENG_EVENT[i].term_done
                     && (SOCK_STATE[i] == scm_pkg::ST_FIN_WAIT || SOCK_STATE[i] == scm_pkg::ST_CLOSE_WT)) begin
          next_state = scm_pkg::ST_CLOSED;
        end else if (ENG_EVENT[i].connected
                     && (SOCK_STATE[i] == scm_pkg::ST_LISTEN || SOCK_STATE[i] == scm_pkg::ST_SYNSENT)) begin
          next_state = scm_pkg::ST_ESTAB;
        end else if (ENG_EVENT[i].peer_fin && SOCK_STATE[i] == scm_pkg::ST_ESTAB) begin
          next_state = scm_pkg::ST_CLOSE_WT;
        end
      end
    end

    // command register and sequencer
    always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
        sock_cmd[i] <= scm_pkg::CMD_RST;
        seq[i]      <= scm_pkg::SQ_IDLE;
      end else begin
        case (seq[i])
          scm_pkg::SQ_IDLE: begin
            if (drop) begin
              sock_cmd[i] <= scm_pkg::CMD_RST;
            end else if (accept) begin
              seq[i] <= scm_pkg::SQ_BUSY;
            end else if (wr_hit && wr_dec.sel == scm_pkg::IDX_CMD[1:0]) begin
              sock_cmd[i] <= w_data[7:0];
            end
          end
          scm_pkg::SQ_BUSY: begin
            if (ENG_DONE[i]) begin
              sock_cmd[i] <= scm_pkg::CMD_RST;
              seq[i]      <= scm_pkg::SQ_IDLE;
            end
          end
          default: seq[i] <= scm_pkg::SQ_IDLE;
        endcase
      end
    end

    // mode, state, events and engine command
    always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
        SOCK_MODE[i]  <= scm_pkg::MODE_RST;
        SOCK_STATE[i] <= scm_pkg::ST_CLOSED;
        sock_evt[i]   <= scm_pkg::EVT_RST;
        ENG_CMD[i]    <= '0;
      end else begin
        if (wr_hit && wr_dec.sel == scm_pkg::IDX_MODE[1:0]) begin
          SOCK_MODE[i] <= w_data[7:0];
        end
        SOCK_STATE[i]    <= next_state;
        sock_evt[i]      <= next_evt;
        ENG_CMD[i].valid <= accept;
        ENG_CMD[i].code  <= sock_cmd[i];
        ENG_CMD[i].proto <= proto;
      end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------

    property p_cmd_clear;
      @(posedge REF_CLK) disable iff (!rst_n)
      (seq[i] == scm_pkg::SQ_BUSY && ENG_DONE[i]) |=> (sock_cmd[i] == 8'h00) && (seq[i] == scm_pkg::SQ_IDLE);
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("command not cleared after done");

    property p_open_tcp;
      @(posedge REF_CLK) disable iff (!rst_n)
      (accept && sock_cmd[i] == 8'h01 && proto == 4'h1) |=> (SOCK_STATE[i] == 8'h13) ##1 ENG_CMD[i].valid == 1'b0;
    endproperty
    a_open_tcp: assert property (p_open_tcp) else $error("tcp open did not give init");

    property p_open_udp;
      @(posedge REF_CLK) disable iff (!rst_n)
      (accept && sock_cmd[i] == 8'h01 && proto == 4'h2) |=> SOCK_STATE[i] == 8'h22 && ENG_CMD[i].valid;
    endproperty
    a_open_udp: assert property (p_open_udp) else $error("udp open did not give datagram state");

    property p_close;
      @(posedge REF_CLK) disable iff (!rst_n)
      (pend && sock_cmd[i] == 8'h10) |=> (SOCK_STATE[i] == 8'h00) && (sock_cmd[i] == 8'h00);
    endproperty
    a_close: assert property (p_close) else $error("close did not reach closed");

    property p_listen_tcp;
      @(posedge REF_CLK) disable iff (!rst_n)
      (accept && (sock_cmd[i] == 8'h02 || sock_cmd[i] == 8'h04 || sock_cmd[i] == 8'h22)) |-> proto == 4'h1;
    endproperty
    a_listen_tcp: assert property (p_listen_tcp) else $error("tcp command accepted outside tcp");

    property p_send_hw_udp;
      @(posedge REF_CLK) disable iff (!rst_n)
      (accept && sock_cmd[i] == 8'h21) |-> proto == 4'h2 && SOCK_STATE[i] == 8'h22;
    endproperty
    a_send_hw_udp: assert property (p_send_hw_udp) else $error("hw address send outside udp");

    property p_estab;
      @(posedge REF_CLK) disable iff (!rst_n)
      (SOCK_STATE[i] == 8'h14 && ENG_EVENT[i].connected && !ENG_EVENT[i].timeout && !pend)
        |=> SOCK_STATE[i] == 8'h17 && sock_evt[i][0];
    endproperty
    a_estab: assert property (p_estab) else $error("listen did not reach established");

    property p_timeout_flag;
      @(posedge REF_CLK) disable iff (!rst_n)
      ENG_EVENT[i].timeout |=> sock_evt[i][3] ##1 (sock_evt[i][3] || $past(evt_clr[3]));
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag lost");

    property p_flag_sticky;
      @(posedge REF_CLK) disable iff (!rst_n)
      (sock_evt[i][2] && !evt_clr[2]) |=> sock_evt[i][2];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without write of one");

    property p_reserved;
      @(posedge REF_CLK) disable iff (!rst_n)
      sock_evt[i][7:5] == 3'b000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved event bits set");

  end

endmodule

// ---- rtl/scm_pkg.sv ----
package scm_pkg;

  // ----------------------------------------------------------------
  // register map (word indices, byte address is four times index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_MODE    = 12'h400;
  localparam logic [11:0] IDX_CMD     = 12'h401;
  localparam logic [11:0] IDX_EVT     = 12'h402;
  localparam logic [11:0] IDX_STATE   = 12'h403;
  localparam logic [11:0] IDX_STRIDE  = 12'h100;
  localparam int          NUM_SOCK    = 4;
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [7:0]  CMD_RST     = 8'h00;
  localparam logic [7:0]  EVT_RST     = 8'h00;
  localparam logic [7:0]  EVT_MASK    = 8'h1F;

  // protocol field codes
  localparam logic [3:0] PROTO_CLOSED = 4'h0;
  localparam logic [3:0] PROTO_TCP    = 4'h1;
  localparam logic [3:0] PROTO_UDP    = 4'h2;
  localparam logic [3:0] PROTO_IP_RAW_MODE  = 4'h3;
  localparam logic [3:0] PROTO_MAC_RAW_MODE = 4'h4;
  localparam logic [3:0] PROTO_PPPOE  = 4'h5;

  // command codes
  localparam logic [7:0] CMD_OPEN     = 8'h01;
  localparam logic [7:0] CMD_LISTEN   = 8'h02;
  localparam logic [7:0] CMD_CONNECT  = 8'h04;
  localparam logic [7:0] CMD_DISCONNECT   = 8'h08;
  localparam logic [7:0] CMD_CLOSE    = 8'h10;
  localparam logic [7:0] CMD_SEND     = 8'h20;
  localparam logic [7:0] CMD_SEND_HW  = 8'h21;
  localparam logic [7:0] CMD_KEEP     = 8'h22;
  localparam logic [7:0] RECEIVE_COMMAND     = 8'h40;

  // socket state codes
  localparam logic [7:0] ST_CLOSED    = 8'h00;
  localparam logic [7:0] ST_INIT      = 8'h13;
  localparam logic [7:0] ST_LISTEN    = 8'h14;
  localparam logic [7:0] ST_SYNSENT   = 8'h15;
  localparam logic [7:0] ST_ESTAB     = 8'h17;
  localparam logic [7:0] ST_FIN_WAIT  = 8'h18;
  localparam logic [7:0] ST_CLOSE_WT  = 8'h1C;
  localparam logic [7:0] ST_DGRAM     = 8'h22;
  localparam logic [7:0] ST_IP_RAW_MODE     = 8'h32;
  localparam logic [7:0] ST_MAC_RAW_MODE    = 8'h42;
  localparam logic [7:0] ST_PPPOE     = 8'h5F;

  // event flag bit positions
  localparam int EVB_CON     = 0;
  localparam int EVB_DISCONNECT  = 1;
  localparam int EVB_RECV    = 2;
  localparam int EVB_TIMEOUT = 3;
  localparam int EVB_SENDOK  = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // events reported by the protocol engine, one-cycle pulses except rx_pending
  typedef struct packed {
    logic connected;
    logic peer_fin;
    logic term_done;
    logic timeout;
    logic send_done;
    logic rx_data;
    logic rx_pending;
  } scm_evt_t;

  // command handed to the protocol engine
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [3:0] proto;
  } scm_cmd_t;

  // register address decode result
  typedef struct packed {
    logic       hit;
    logic [1:0] sock;
    logic [1:0] sel;
  } scm_dec_t;

  typedef enum logic {SQ_IDLE, SQ_BUSY} scm_seq_t;

endpackage

// ---- testbench/socket_command_status_engine_test.sv ----
`timescale 1ns/1ps
module socket_command_status_engine_test;
  // ----------
  // signals
  // ----------
  logic                    REF_CLK, RESET_N;
  logic [15:0]             S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]             S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]              S_AXI_WSTRB, ENG_DONE;
  logic                    S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic                    S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
  logic                    S_AXI_RVALID, S_AXI_RREADY;
  logic [1:0]              S_AXI_BRESP, S_AXI_RRESP;
  scm_pkg::scm_cmd_t [3:0] ENG_CMD;
  scm_pkg::scm_evt_t [3:0] ENG_EVENT;
  logic [3:0][7:0]         SOCK_MODE, SOCK_STATE;
  int                      n_mismatch, compares, s;
  localparam logic [11:0]  MO = 12'h0, CM = 12'h1, EV = 12'h2, ST = 12'h3;
  localparam logic [6:0]   E_CON = 7'h40, E_FIN = 7'h20, E_TERM = 7'h10, E_TO = 7'h08;
  localparam logic [6:0]   E_SENT = 7'h04, E_RX = 7'h02;
  // socket, protocol field, state expected after open
  localparam logic [13:0]  ROWS [8] = '{14'h0113, 14'h0222, 14'h0332, 14'h0442,
                                        14'h055F, 14'h1400, 14'h1500, 14'h3332};

  scm_socket_engine u_scm_socket_engine (
    .REF_CLK, .RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .ENG_CMD, .ENG_DONE, .ENG_EVENT, .SOCK_MODE, .SOCK_STATE
  );

  // 200 MHz clock
  initial begin
    REF_CLK = 0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  // ----------
  // tasks
  // ----------
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_data({30'h0, got}, {30'h0, exp});
  endtask

  function automatic logic [15:0] ra(input int k, input logic [11:0] r);
    return {2'b00, scm_pkg::IDX_MODE + scm_pkg::IDX_STRIDE * 12'(k) + r, 2'b00};
  endfunction

  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [15:0] a, input logic [7:0] v, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, v};
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    while (!(aw && w)) begin
      @(posedge REF_CLK);
      if (!aw && S_AXI_AWREADY === 1'b1) begin
        aw = 1;
        S_AXI_AWVALID <= 0;
      end
      if (!w && S_AXI_WREADY === 1'b1) begin
        w = 1;
        S_AXI_WVALID <= 0;
      end
    end
    do @(posedge REF_CLK); while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 0;
    chk_resp(S_AXI_BRESP, er);
  endtask

  task automatic axi_rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do @(posedge REF_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 0;
    do @(posedge REF_CLK); while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 0;
    chk_resp(S_AXI_RRESP, er);
    chk_data(S_AXI_RDATA, {24'h0, e});
  endtask

  task automatic wr(input int k, input logic [11:0] r, input logic [7:0] v);
    axi_wr(ra(k, r), v, scm_pkg::RESP_OKAY);
  endtask

  task automatic rs(input int k, input logic [11:0] r, input logic [7:0] e);
    axi_rd(ra(k, r), e, scm_pkg::RESP_OKAY);
  endtask

  // accepted command: wait for the engine pulse, then answer done if asked
  task automatic go(input int k, input logic [7:0] c, input bit dn);
    wr(k, CM, c);
    do @(posedge REF_CLK); while (ENG_CMD[k].valid !== 1'b1);
    chk_data(ENG_CMD[k].code, c);
    if (dn) begin
      ENG_DONE[k] <= 1;
      @(posedge REF_CLK);
      ENG_DONE[k] <= 0;
      @(posedge REF_CLK);
    end
  endtask

  // refused command: register clears on its own
  task automatic no(input int k, input logic [7:0] c);
    wr(k, CM, c);
    repeat (2) @(posedge REF_CLK);
    rs(k, CM, 8'h00);
  endtask

  task automatic ev(input int k, input logic [6:0] e);
    ENG_EVENT[k] <= e;
    @(posedge REF_CLK);
    ENG_EVENT[k] <= '0;
    @(posedge REF_CLK);
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------
  // sequence
  // ----------
  initial begin
    {RESET_N, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, ENG_DONE} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    ENG_EVENT = '0;
    S_AXI_WSTRB = 4'hF;
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1;
    repeat (4) @(posedge REF_CLK);
    for (int i = 0; i < 8; i++) begin
      s = ROWS[i][13:12];
      wr(s, MO, {4'h0, ROWS[i][11:8]});
      if (ROWS[i][7:0] === 8'h00) no(s, 8'h01);
      else go(s, 8'h01, 1);
      rs(s, ST, ROWS[i][7:0]);
      chk_data(32'(SOCK_STATE[s]), 32'(ROWS[i][7:0]));
      chk_data(32'(SOCK_MODE[s]), 32'(ROWS[i][11:8]));
      chk_data(32'(ENG_CMD[s].proto), 32'(ROWS[i][11:8]));
      rs(s, CM, 8'h00);
      go(s, 8'h10, 0);
      rs(s, ST, 8'h00);
    end
    // server path, flags and their clearing
    wr(0, MO, 8'h01);
    go(0, 8'h01, 1);
    go(0, 8'h02, 1);
    rs(0, ST, 8'h14);
    ev(0, E_CON);
    rs(0, ST, 8'h17);
    ev(0, E_FIN);
    rs(0, ST, 8'h1C);
    rs(0, EV, 8'h03);
    wr(0, EV, 8'h01);
    rs(0, EV, 8'h02);
    go(0, 8'h20, 1);
    ev(0, E_SENT);
    ENG_EVENT[0].rx_pending <= 1;
    go(0, 8'h40, 1);
    ENG_EVENT[0].rx_pending <= 0;
    rs(0, EV, 8'h16);
    ev(0, E_TO);
    rs(0, ST, 8'h00);
    rs(0, EV, 8'h1E);
    wr(0, EV, 8'hFF);
    rs(0, EV, 8'h00);
    // client path with probe and orderly termination
    wr(3, MO, 8'h01);
    go(3, 8'h01, 1);
    go(3, 8'h04, 1);
    ev(3, E_CON);
    go(3, 8'h22, 1);
    go(3, 8'h08, 1);
    ev(3, E_TERM);
    rs(3, ST, 8'h00);
    rs(3, EV, 8'h03);
    // datagram socket refuses connection commands
    wr(2, MO, 8'h02);
    go(2, 8'h01, 1);
    no(2, 8'h02);
    no(2, 8'h04);
    no(2, 8'h08);
    no(2, 8'h22);
    go(2, 8'h21, 1);
    wr(2, ST, 8'h55);
    rs(2, ST, 8'h22);
    ev(2, E_RX);
    rs(2, EV, 8'h04);
    // write without byte lane 0 leaves the register alone
    S_AXI_WSTRB <= 4'hE;
    wr(2, MO, 8'h05);
    S_AXI_WSTRB <= 4'hF;
    rs(2, MO, 8'h02);
    axi_wr(16'h0000, 8'h01, scm_pkg::RESP_SLVERR);
    axi_rd(16'h0000, 8'h00, scm_pkg::RESP_SLVERR);
    // reset in mid-run returns registers to their reset values
    RESET_N <= 0;
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1;
    repeat (4) @(posedge REF_CLK);
    rs(2, MO, 8'h00);
    rs(2, ST, 8'h00);
    rs(2, EV, 8'h00);
    rs(2, CM, 8'h00);
    tally_and_finish;
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
